// ### verilog/boot_init_pkg.sv
// Purpose: shared constants for the post-reset register initialiser and the register space
// Assumes: 32-bit register writes, one word per register
// Notes:   register offsets inside the internal space are a local layout
package boot_init_pkg;

    // Register identities inside the internal space
    typedef enum logic [4:0] {
        reg_reset_mode, reg_space_base, reg_sys_prot, reg_bus_cfg,
        reg_cs0_opt, reg_cs0_base, reg_cs1_opt, reg_cs1_base,
        reg_cs2_opt, reg_cs2_base, reg_cs3_opt, reg_cs3_base,
        reg_cs4_opt, reg_cs4_base, reg_cs5_opt, reg_cs5_base,
        reg_sdram_mode, reg_prescaler, reg_refresh_timer
    } reg_id_t;

    localparam int          NUM_REGS  = 19;
    localparam logic [15:0] REG_OFF [NUM_REGS] = '{
        16'h0000, 16'h0004, 16'h0008, 16'h000c,
        16'h0010, 16'h0014, 16'h0018, 16'h001c,
        16'h0020, 16'h0024, 16'h0028, 16'h002c,
        16'h0030, 16'h0034, 16'h0038, 16'h003c,
        16'h0040, 16'h0044, 16'h0048
    };

    // Internal space placement
    localparam logic [31:0] SPACE_BASE_RESET = 32'h0f000000;
    localparam logic [31:0] SPACE_MASK       = 32'hffff0000;

    // Reset configuration word in the boot device
    localparam logic [4:0]  CFG_ADDR_STEP    = 5'h08;
    localparam logic [7:0]  CFG_B0_FLASH     = 8'h0c;
    localparam logic [7:0]  CFG_B0_EEPROM    = 8'h04;
    localparam logic [7:0]  CFG_B1           = 8'h72;
    localparam logic [7:0]  CFG_B2           = 8'h36;
    localparam logic [7:0]  CFG_B3           = 8'h5a;
    localparam logic [2:0]  CFG_SETTLE       = 3'h2;

    // Values written by the initialiser (100 MHz bus timing)
    localparam logic [31:0] VAL_RESET_MODE   = 32'h00000001;
    localparam logic [31:0] VAL_SPACE_BASE   = 32'h04700000;
    localparam logic [31:0] VAL_SYS_PROT     = 32'h0fffffc3;
    localparam logic [31:0] VAL_BUS_CFG      = 32'h100c0000;
    localparam logic [31:0] VAL_FL_BASE_8M   = 32'hff801801;
    localparam logic [31:0] VAL_FL_BASE_16M  = 32'hff001801;
    localparam logic [31:0] VAL_FL_BASE_32M  = 32'hfe001801;
    localparam logic [31:0] VAL_FL_OPT_8M    = 32'hff800876;
    localparam logic [31:0] VAL_FL_OPT_16M   = 32'hff000876;
    localparam logic [31:0] VAL_FL_OPT_32M   = 32'hfe000876;
    localparam logic [31:0] VAL_FL4_BASE_8M  = 32'hc3801801;
    localparam logic [31:0] VAL_FL4_BASE_16M = 32'hc3001801;
    localparam logic [31:0] VAL_FL4_BASE_32M = 32'hc2001801;
    localparam logic [31:0] VAL_CTRL_BASE    = 32'h04501801;
    localparam logic [31:0] VAL_SMALL_OPT    = 32'hffff8010;
    localparam logic [31:0] VAL_SDRAM_BASE   = 32'h00000041;
    localparam logic [31:0] VAL_SDRAM_OPT    = 32'hfe002ec0;
    localparam logic [31:0] VAL_EE_BASE_CS4  = 32'hc2000801;
    localparam logic [31:0] VAL_EE_BASE_CS0  = 32'hfff00801;
    localparam logic [31:0] VAL_EE_OPT       = 32'hffff8866;
    localparam logic [31:0] VAL_LINE_BASE    = 32'h04600801;
    localparam logic [31:0] VAL_LINE_OPT     = 32'hffff8e56;
    localparam logic [31:0] VAL_PCI_IC_BASE  = 32'h04731801;
    localparam logic [31:0] VAL_SDRAM_MODE   = 32'hc34f36a3;
    localparam logic [31:0] VAL_PRESCALER    = 32'h00002800;
    localparam logic [31:0] VAL_REFRESH      = 32'h00000013;
    // Prescale factor sits in the second byte (bits 15:8) of its register
    localparam int          PRESCALE_LSB     = 8;

    // Flash module size codes
    localparam logic [1:0]  SIZE_8M          = 2'h0;
    localparam logic [1:0]  SIZE_16M         = 2'h1;

    // APB map of the initialiser
    localparam logic [11:0] APB_CTRL_OFF     = 12'h000;
    localparam logic [11:0] APB_STATUS_OFF   = 12'h004;
    localparam int          CTRL_START_BIT   = 0;
    localparam int          CTRL_SIZE_LSB    = 1;
    localparam logic [1:0]  CTRL_SIZE_RESET  = 2'h2;

endpackage

// ### verilog/boot_init_if.sv
// Purpose: write path from the initialiser into the internal register space
// Assumes: one clock shared by both ends
// Notes:   req is held with addr and wdata until ack
`timescale 1ns/1ps
interface boot_init_if;
    logic        req;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        ack;
    logic        ready;

    modport space (input req, input addr, input wdata, output ack, output ready);
    modport init  (output req, output addr, output wdata, input ack, input ready);
endinterface

// ### verilog/reg_space.sv
// Purpose: internal register space end: boot configuration word, register file, refresh timing
// Assumes: strap is asynchronous, pclk is the bus clock
// Notes:   writes outside the current window are acknowledged and dropped
`timescale 1ns/1ps
module reg_space (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Link to the initialiser
    boot_init_if.space                link,
    // Board strap: eeprom on the boot chip select
    input  wire logic                 boot_eeprom,
    // Observed state
    output logic [31:0]               boot_cfg_word,
    output logic [31:0]               space_base,
    output logic                      refresh_tick,
    output logic                      write_miss
);
    logic        strap_s1_ff;
    logic        strap_s2_ff;
    logic [2:0]  cfg_step_ff;
    logic [31:0] cfg_word_ff;
    logic        ready_ff;
    logic        ack_ff;
    logic        miss_ff;
    logic [31:0] base_ff;
    logic [31:0] regs_ff [boot_init_pkg::NUM_REGS];
    logic [31:0] pre_cnt_ff;
    logic [31:0] tmr_cnt_ff;
    logic        refresh_ff;
    logic [1:0]  cfg_idx;
    logic [7:0]  pre_div;
    logic [4:0]  cfg_addr;
    logic [7:0]  cfg_byte;
    logic        in_window;
    logic        hit;
    logic [4:0]  hit_idx;
    logic        take;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
        end else begin
            strap_s1_ff <= boot_eeprom;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    // Boot device byte at 0x0/0x8/0x10/0x18
    // Byte index counts from the end of the strap settling wait
    assign cfg_idx  = 2'(cfg_step_ff - boot_init_pkg::CFG_SETTLE);
    assign cfg_addr = 5'(cfg_idx * boot_init_pkg::CFG_ADDR_STEP);
    always_comb begin
        case (cfg_addr)
            5'h00:   cfg_byte = strap_s2_ff ? boot_init_pkg::CFG_B0_EEPROM
                                            : boot_init_pkg::CFG_B0_FLASH;
            5'h08:   cfg_byte = boot_init_pkg::CFG_B1;
            5'h10:   cfg_byte = boot_init_pkg::CFG_B2;
            default: cfg_byte = boot_init_pkg::CFG_B3;
        endcase
    end

    // Waits two cycles for the strap to settle, then reads four bytes
    // First byte hangs on the strap, so no read before the sync output is valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_step_ff <= 3'h0;
            cfg_word_ff <= 32'h00000000;
            ready_ff    <= 1'b0;
        end else if (!ready_ff) begin
            cfg_step_ff <= cfg_step_ff + 3'h1;
            if (cfg_step_ff >= boot_init_pkg::CFG_SETTLE) begin
                cfg_word_ff <= {cfg_word_ff[23:0], cfg_byte};
            end
            ready_ff    <= (cfg_step_ff == boot_init_pkg::CFG_SETTLE + 3'h3);
        end
    end

    assign in_window = ((link.addr & boot_init_pkg::SPACE_MASK) == base_ff);
    always_comb begin
        hit     = 1'b0;
        hit_idx = 5'h00;
        for (int i = 0; i < boot_init_pkg::NUM_REGS; i++) begin
            if (in_window && link.addr[15:0] == boot_init_pkg::REG_OFF[i]) begin
                hit     = 1'b1;
                hit_idx = 5'(i);
            end
        end
    end
    assign take = link.req && ready_ff && !ack_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_ff  <= 1'b0;
            miss_ff <= 1'b0;
        end else begin
            ack_ff  <= take;
            miss_ff <= take && !hit;
        end
    end

    // Window starts at the reset placement and moves on the base write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_ff <= boot_init_pkg::SPACE_BASE_RESET;
        end else if (take && hit && hit_idx == 5'(boot_init_pkg::reg_space_base)) begin
            base_ff <= link.wdata & boot_init_pkg::SPACE_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < boot_init_pkg::NUM_REGS; i++) begin
                regs_ff[i] <= 32'h00000000;
            end
        end else if (take && hit) begin
            regs_ff[hit_idx] <= link.wdata;
        end
    end

    // Refresh: clock / (prescaler+1), then / (timer+1)
    assign pre_div = regs_ff[boot_init_pkg::reg_prescaler][boot_init_pkg::PRESCALE_LSB +: 8];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt_ff <= 32'h00000000;
            tmr_cnt_ff <= 32'h00000000;
            refresh_ff <= 1'b0;
        end else begin
            refresh_ff <= 1'b0;
            if (pre_cnt_ff >= {24'h000000, pre_div}) begin
                pre_cnt_ff <= 32'h00000000;
                if (tmr_cnt_ff >= regs_ff[boot_init_pkg::reg_refresh_timer]) begin
                    tmr_cnt_ff <= 32'h00000000;
                    refresh_ff <= (regs_ff[boot_init_pkg::reg_refresh_timer] != 32'h00000000);
                end else begin
                    tmr_cnt_ff <= tmr_cnt_ff + 32'h00000001;
                end
            end else begin
                pre_cnt_ff <= pre_cnt_ff + 32'h00000001;
            end
        end
    end

    assign link.ack      = ack_ff;
    assign link.ready    = ready_ff;
    assign boot_cfg_word = cfg_word_ff;
    assign space_base    = base_ff;
    assign refresh_tick  = refresh_ff;
    assign write_miss    = miss_ff;
endmodule

// ### verilog/boot_initialiser.sv
// Purpose: writes the post-reset register set into the internal space, under APB control
// Assumes: register space end answers each write with a one-cycle ack
// Notes:   timing values are tuned for a 100 MHz bus; slower buses work but lose speed
// Operation
// - start only after reset, write all first
// - config word bytes at 0x0,0x8,0x10,0x18
// - flash boot first byte is 0C
// - eeprom boot first byte is 04
// - remaining bytes 72, 36, 5A
// - first writes go to 0x0F000000
// - reset mode register gets 0001
// - relocate space base to 04700000
// - system protection register gets FFFFFC3
// - bus configuration register gets 100C0000
// - timing values assume 100 MHz bus
// - flash boot window base by size
// - flash option value by module size
// - control bank on select one
// - SDRAM on select two
// - eeprom on select four when flash boots
// - line interface port on select five
// - PCI interrupt controller on select three
// - eeprom boot swaps select zero and four
// - SDRAM mode register gets C34F36A3
// - refresh prescaler gets 2800
// - refresh timer gets 13
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module boot_initialiser (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Board strap: eeprom on the boot chip select
    input  wire logic                 boot_eeprom,
    // Completion
    output logic                      init_done,
    // Link to the register space
    boot_init_if.init                 link
);
    typedef enum {st_idle, st_wait_ready, st_issue, st_wait_ack, st_done} state_t;

    localparam logic [4:0] LAST_STEP = 5'(boot_init_pkg::NUM_REGS - 1);

    state_t      state_ff;
    logic        strap_s1_ff;
    logic        strap_s2_ff;
    logic        eeprom_ff;
    logic [1:0]  size_ff;
    logic        start_ff;
    logic [4:0]  step_ff;
    logic [31:0] base_ff;
    logic        req_ff;
    logic [31:0] addr_ff;
    logic [31:0] wdata_ff;
    logic        done_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        apb_access;
    logic        ctrl_sel;
    logic        stat_sel;
    logic [31:0] fl_base0;
    logic [31:0] fl_base4;
    logic [31:0] fl_opt;
    logic [31:0] step_val;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
        end else begin
            strap_s1_ff <= boot_eeprom;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    // APB: answer in the second access cycle
    assign apb_access = psel && penable && !pready_ff;
    assign ctrl_sel   = (paddr == boot_init_pkg::APB_CTRL_OFF);
    assign stat_sel   = (paddr == boot_init_pkg::APB_STATUS_OFF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= apb_access;
            pslverr_ff <= apb_access && !ctrl_sel && !stat_sel;
            prdata_ff  <= 32'h00000000;
            if (apb_access && !pwrite && ctrl_sel) begin
                prdata_ff <= {29'h00000000, size_ff, 1'b0};
            end else if (apb_access && !pwrite && stat_sel) begin
                prdata_ff <= {19'h00000, step_ff, 5'h00, eeprom_ff, done_ff,
                              (state_ff != st_idle && state_ff != st_done)};
            end
        end
    end

    // Size field steers values; size is frozen while a run is active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            size_ff  <= boot_init_pkg::CTRL_SIZE_RESET;
            start_ff <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            if (pready_ff && psel && pwrite && ctrl_sel) begin
                start_ff <= pwdata[boot_init_pkg::CTRL_START_BIT];
                if (state_ff == st_idle || state_ff == st_done) begin
                    size_ff <= pwdata[boot_init_pkg::CTRL_SIZE_LSB +: 2];
                end
            end
        end
    end

    // Flash values by module size
    always_comb begin
        case (size_ff)
            boot_init_pkg::SIZE_8M: begin
                fl_base0 = boot_init_pkg::VAL_FL_BASE_8M;
                fl_base4 = boot_init_pkg::VAL_FL4_BASE_8M;
                fl_opt   = boot_init_pkg::VAL_FL_OPT_8M;
            end
            boot_init_pkg::SIZE_16M: begin
                fl_base0 = boot_init_pkg::VAL_FL_BASE_16M;
                fl_base4 = boot_init_pkg::VAL_FL4_BASE_16M;
                fl_opt   = boot_init_pkg::VAL_FL_OPT_16M;
            end
            default: begin
                fl_base0 = boot_init_pkg::VAL_FL_BASE_32M;
                fl_base4 = boot_init_pkg::VAL_FL4_BASE_32M;
                fl_opt   = boot_init_pkg::VAL_FL_OPT_32M;
            end
        endcase
    end

    // Step order follows the register identities: option precedes base
    always_comb begin
        case (step_ff)
            5'(boot_init_pkg::reg_reset_mode):    step_val = boot_init_pkg::VAL_RESET_MODE;
            5'(boot_init_pkg::reg_space_base):    step_val = boot_init_pkg::VAL_SPACE_BASE;
            5'(boot_init_pkg::reg_sys_prot):      step_val = boot_init_pkg::VAL_SYS_PROT;
            5'(boot_init_pkg::reg_bus_cfg):       step_val = boot_init_pkg::VAL_BUS_CFG;
            5'(boot_init_pkg::reg_cs0_opt):       step_val = eeprom_ff ? boot_init_pkg::VAL_EE_OPT : fl_opt;
            5'(boot_init_pkg::reg_cs0_base):      step_val = eeprom_ff ? boot_init_pkg::VAL_EE_BASE_CS0 : fl_base0;
            5'(boot_init_pkg::reg_cs1_opt):       step_val = boot_init_pkg::VAL_SMALL_OPT;
            5'(boot_init_pkg::reg_cs1_base):      step_val = boot_init_pkg::VAL_CTRL_BASE;
            5'(boot_init_pkg::reg_cs2_opt):       step_val = boot_init_pkg::VAL_SDRAM_OPT;
            5'(boot_init_pkg::reg_cs2_base):      step_val = boot_init_pkg::VAL_SDRAM_BASE;
            5'(boot_init_pkg::reg_cs3_opt):       step_val = boot_init_pkg::VAL_SMALL_OPT;
            5'(boot_init_pkg::reg_cs3_base):      step_val = boot_init_pkg::VAL_PCI_IC_BASE;
            5'(boot_init_pkg::reg_cs4_opt):       step_val = eeprom_ff ? fl_opt : boot_init_pkg::VAL_EE_OPT;
            5'(boot_init_pkg::reg_cs4_base):      step_val = eeprom_ff ? fl_base4 : boot_init_pkg::VAL_EE_BASE_CS4;
            5'(boot_init_pkg::reg_cs5_opt):       step_val = boot_init_pkg::VAL_LINE_OPT;
            5'(boot_init_pkg::reg_cs5_base):      step_val = boot_init_pkg::VAL_LINE_BASE;
            5'(boot_init_pkg::reg_sdram_mode):    step_val = boot_init_pkg::VAL_SDRAM_MODE;
            5'(boot_init_pkg::reg_prescaler):     step_val = boot_init_pkg::VAL_PRESCALER;
            default:                              step_val = boot_init_pkg::VAL_REFRESH;
        endcase
    end

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= st_idle;
            step_ff   <= 5'h00;
            eeprom_ff <= 1'b0;
            done_ff   <= 1'b0;
        end else begin
            case (state_ff)
                st_idle, st_done: begin
                    if (start_ff) begin
                        state_ff  <= st_wait_ready;
                        step_ff   <= 5'h00;
                        eeprom_ff <= strap_s2_ff;
                        done_ff   <= 1'b0;
                    end
                end
                st_wait_ready: begin
                    if (link.ready) begin
                        state_ff <= st_issue;
                    end
                end
                st_issue: begin
                    state_ff <= st_wait_ack;
                end
                st_wait_ack: begin
                    if (link.ack) begin
                        if (step_ff == LAST_STEP) begin
                            state_ff <= st_done;
                            done_ff  <= 1'b1;
                        end else begin
                            state_ff <= st_issue;
                            step_ff  <= step_ff + 5'h01;
                        end
                    end
                end
                default: begin
                    state_ff <= st_idle;
                end
            endcase
        end
    end

    // Space base: reset placement until the relocation write is acknowledged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_ff <= boot_init_pkg::SPACE_BASE_RESET;
        end else if (state_ff == st_wait_ready) begin
            base_ff <= boot_init_pkg::SPACE_BASE_RESET;
        end else if (state_ff == st_wait_ack && link.ack
                     && step_ff == 5'(boot_init_pkg::reg_space_base)) begin
            base_ff <= boot_init_pkg::VAL_SPACE_BASE;
        end
    end

    // Request held stable until ack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_ff   <= 1'b0;
            addr_ff  <= 32'h00000000;
            wdata_ff <= 32'h00000000;
        end else if (state_ff == st_issue) begin
            req_ff   <= 1'b1;
            addr_ff  <= base_ff | {16'h0000, boot_init_pkg::REG_OFF[step_ff]};
            wdata_ff <= step_val;
        end else if (link.ack) begin
            req_ff   <= 1'b0;
        end
    end

    assign link.req   = req_ff;
    assign link.addr  = addr_ff;
    assign link.wdata = wdata_ff;
    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign init_done  = done_ff;
endmodule

// ### bench/link_properties.sv
// Purpose: link checks between the initialiser and the register space
// Assumes: one clock, presetn asynchronous and active low
// Notes:   sees only the interface signals, so it can judge either end
`timescale 1ns/1ps
module link_properties (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Link
    input wire logic        req,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        ack,
    input wire logic        ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Relocating write acked, then the mandatory idle cycle
    sequence reloc_s; req && ack && addr == 32'h0f000004; endsequence
    sequence next_s; !req ##1 req; endsequence
    chk_take_ack: assert property (req && ready && !ack |=> ack)
        else $error("write taken but not acked");
    chk_ack_single: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    chk_req_holds: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
        else $error("request changed before ack");
    chk_idle_gap: assert property (ack |=> !req)
        else $error("no idle cycle after ack");
    chk_wait_ready: assert property (req |-> ready)
        else $error("write issued before space ready");
    chk_ack_cause: assert property (ack |-> $past(req) && $past(ready))
        else $error("ack without a request");
    chk_mode_value: assert property (req && addr == 32'h0f000000 |-> wdata == 32'h00000001)
        else $error("reset mode value wrong");
    chk_base_value: assert property (req && addr == 32'h0f000004 |-> wdata == 32'h04700000)
        else $error("space base value wrong");
    chk_relocated_base: assert property (reloc_s ##1 next_s |-> addr[31:16] == 16'h0470)
        else $error("write after relocation not at new base");
    chk_window_only: assert property (req |-> addr[31:16] == 16'h0f00 || addr[31:16] == 16'h0470)
        else $error("write outside either window");
endmodule

// ### bench/board_boot_register_init_bench.sv
// Purpose: runs every strap and flash size through the initialiser over APB
// Assumes: 50 MHz pclk, strap held across each reset
// Notes:   expected write list built from the board value set
`timescale 1ns/1ps
module board_boot_register_init_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic        boot_eeprom = 1'b0;
    logic [31:0] prdata, boot_cfg_word, space_base;
    logic        pready, pslverr, init_done, refresh_tick, write_miss;
    int          n_miss = 0;
    logic [31:0] wa [32];
    logic [31:0] wd [32];
    int          nw = 0;
    int          err_total = 0;
    int          checks_done = 0;
    boot_init_if lk ();
    always #10 pclk = ~pclk;
    reg_space reg_space_i (.pclk(pclk), .presetn(presetn), .link(lk), .boot_eeprom(boot_eeprom),
        .boot_cfg_word(boot_cfg_word), .space_base(space_base), .refresh_tick(refresh_tick),
        .write_miss(write_miss));
    boot_initialiser boot_initialiser_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .boot_eeprom(boot_eeprom), .init_done(init_done), .link(lk));
    link_properties link_properties_i (.pclk(pclk), .presetn(presetn), .req(lk.req), .addr(lk.addr),
        .wdata(lk.wdata), .ack(lk.ack), .ready(lk.ready));
    // Log every acked link write and every dropped one; cleared by reset
    always @(posedge pclk) begin
        if (!presetn) begin
            nw <= 0;
            n_miss <= 0;
        end else begin
            if (lk.req === 1'b1 && lk.ack === 1'b1 && nw < 32) begin
                wa[nw] <= lk.addr;
                wd[nw] <= lk.wdata;
                nw <= nw + 1;
            end
            if (write_miss !== 1'b0) n_miss <= n_miss + 1;
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Selector: 0 link ready, 1 init done, 2 refresh tick
    task automatic wait_hi(input int sel, output int n);
        logic v;
        n = 0;
        v = 1'b0;
        do begin
            @(posedge pclk);
            n++;
            v = sel == 0 ? lk.ready : (sel == 1 ? init_done : refresh_tick);
        end while (v !== 1'b1 && n < 3000);
        if (v !== 1'b1) begin err_total++; conclude(); end
    endtask
    // Called just after an edge; leaves one edge before returning
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin err_total++; conclude(); end
        @(posedge pclk);
    endtask
    task automatic run_case(input logic ee, input logic [1:0] s);
        logic [31:0] t [19];
        logic [31:0] q, fo, fb, f4;
        logic        e;
        int          n;
        t = '{32'h00000001, 32'h04700000, 32'h0fffffc3, 32'h100c0000, 32'h0, 32'h0,
              32'hffff8010, 32'h04501801, 32'hfe002ec0, 32'h00000041, 32'hffff8010, 32'h04731801,
              32'h0, 32'h0, 32'hffff8e56, 32'h04600801, 32'hc34f36a3, 32'h00002800, 32'h00000013};
        fo = s == 2'h0 ? 32'hff800876 : (s == 2'h1 ? 32'hff000876 : 32'hfe000876);
        fb = {fo[31:16], 16'h1801};
        // Flash window moved down under the secondary select
        f4 = fb - 32'h3c000000;
        t[4] = ee ? 32'hffff8866 : fo;
        t[5] = ee ? 32'hfff00801 : fb;
        t[12] = ee ? fo : 32'hffff8866;
        t[13] = ee ? f4 : 32'hc2000801;
        boot_eeprom <= ee;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmp("space_base", 32'h0f000000, space_base);
        apb(1'b0, 12'h000, 32'h0, q, e);
        cmp("ctrl_reset", 32'h00000004, q);
        apb(1'b0, 12'h008, 32'h0, q, e);
        cmp("unmapped_err", 32'h00000001, {31'h0, e});
        wait_hi(0, n);
        cmp("cfg_word", {ee ? 8'h04 : 8'h0c, 24'h72365a}, boot_cfg_word);
        apb(1'b1, 12'h000, {29'h0, s, 1'b1}, q, e);
        wait_hi(1, n);
        apb(1'b0, 12'h004, 32'h0, q, e);
        cmp("status", {29'h0, ee, 2'h2}, q & 32'h00000007);
        cmp("write_count", 32'd19, 32'(nw));
        cmp("write_miss", 32'h00000000, 32'(n_miss));
        for (int i = 0; i < 19; i++) begin
            cmp("write_addr", (i < 2 ? 32'h0f000000 : 32'h04700000) | 32'(i * 4), wa[i]);
            cmp("write_data", t[i], wd[i]);
        end
        cmp("space_base", 32'h04700000, space_base);
        wait_hi(2, n);
        wait_hi(2, n);
        cmp("refresh_period", 32'd820, 32'(n));
        $display("case eeprom=%0d size=%0d ended", ee, s);
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            run_case(k >= 3, 2'(k % 3));
        end
        conclude();
    end
endmodule
